// [logic/otcpu_timing_seq.sv]
// instruction fetch and execution-cycle sequencer of the single-cycle core
// assumes code memory answers code_byte combinationally for code_addr, same clock
// What this block does
// - copy bank register to accumulator: one byte, one cycle
// - accumulator load from direct byte: two bytes, two cycles
// - accumulator load through indirect pointer: one byte, two cycles
// - immediate load to accumulator or bank register: two bytes, two cycles
// - accumulator to bank register: one byte, two cycles
// - direct byte to bank register: two bytes, four cycles
// - store register or accumulator to direct: 2/3; immediate to direct: 3/3
// - direct to direct 3 bytes 4 cycles; indirect to direct 2/4
// - indirect writes take 3 cycles; accumulator 1 byte, others 2
// - data pointer immediate load: three bytes, three cycles
// - code byte read indexed by accumulator: one byte, four cycles
// - on-chip aux RAM transfers, 8 or 16-bit address: one byte, three cycles
// - aux RAM transfers to external RAM are unsupported, no timing
// - push direct 2 bytes 4 cycles; pop direct 2 bytes 3 cycles
// - exchange bank 1/3, direct 2/4, indirect and low nibble 1/4
// - add with or without carry: bank 1/2, direct 2/3, indirect 1/3, immediate 2/2
// - subtract with borrow: same lengths and cycles as add
// - and, or, xor as add; direct destination 4 cycles, 2 or 3 bytes
// - clear, rotates, swap one byte one cycle; complement two cycles
`timescale 1ns/100ps
`include "otcpu_params.svh"

module otcpu_timing_seq (
  input wire logic ref_clk,
  input wire logic rst,
  output logic [15:0] code_addr,
  input wire logic [7:0] code_byte,
  input wire otcpu_pkg::otcpu_form_e form_in,
  output otcpu_pkg::otcpu_insn_s insn,
  output otcpu_pkg::otcpu_timing_s insn_timing,
  output logic [2:0] exec_cycle,
  output logic insn_done,
  output logic unsupported
);
  import otcpu_pkg::*;

  // length and timing of each operand form
  function automatic otcpu_timing_s timing_of(input otcpu_form_e f);
    otcpu_timing_s t;
    t = otcpu_timing_s'(`OTCPU_T_NONE);
    // default covers enum codes past the list; they must not be driven
    case (f)

      // loads into the accumulator
      OTCPU_F_MOV_A_BANK: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C1);
      end
      OTCPU_F_MOV_A_DIR: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C2);
      end
      OTCPU_F_MOV_A_IND: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C2);
      end
      OTCPU_F_MOV_A_IMM: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C2);
      end

      // loads into a bank register
      OTCPU_F_MOV_BANK_IMM: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C2);
      end
      OTCPU_F_MOV_BANK_A: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C2);
      end
      OTCPU_F_MOV_BANK_DIR: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C4);
      end

      // stores to a directly addressed byte
      OTCPU_F_MOV_DIR_A: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C3);
      end
      OTCPU_F_MOV_DIR_BANK: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C3);
      end
      OTCPU_F_MOV_DIR_IMM: begin
        t = otcpu_timing_s'(`OTCPU_T_B3_C3);
      end
      OTCPU_F_MOV_DIR_DIR: begin
        t = otcpu_timing_s'(`OTCPU_T_B3_C4);
      end
      OTCPU_F_MOV_DIR_IND: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C4);
      end

      // stores through the indirect pointer register
      OTCPU_F_MOV_IND_A: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C3);
      end
      OTCPU_F_MOV_IND_DIR: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C3);
      end
      OTCPU_F_MOV_IND_IMM: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C3);
      end

      // sixteen-bit data pointer load
      OTCPU_F_LOAD_DATA_POINTER: begin
        t = otcpu_timing_s'(`OTCPU_T_B3_C3);
      end

      // code byte reads indexed by the accumulator
      OTCPU_F_CODE_BYTE_READ_DP: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C4);
      end
      OTCPU_F_CODE_BYTE_READ_PC: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C4);
      end

      // aux ram transfers: only the on-chip ram has a timing
      // the external form gets the zero word and is refused by the sequencer
      OTCPU_F_AUX_RD_8: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C3);
      end
      OTCPU_F_AUX_RD_16: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C3);
      end
      OTCPU_F_AUX_WR_8: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C3);
      end
      OTCPU_F_AUX_WR_16: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C3);
      end
      OTCPU_F_AUX_EXTERNAL: begin
        t = otcpu_timing_s'(`OTCPU_T_NONE);
      end

      // stack transfers
      OTCPU_F_PUSH: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C4);
      end
      OTCPU_F_POP: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C3);
      end

      // exchanges with the accumulator
      OTCPU_F_XCH_BANK: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C3);
      end
      OTCPU_F_XCH_DIR: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C4);
      end
      OTCPU_F_XCH_IND: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C4);
      end
      OTCPU_F_LOW_NIBBLE_EXCHANGE: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C4);
      end

      // add, add_with_carry, subtract_with_borrow and the three logic ops share these
      // one form per operand kind keeps the classifier outside small
      OTCPU_F_ALU_BANK: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C2);
      end
      OTCPU_F_ALU_DIR: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C3);
      end
      OTCPU_F_ALU_IND: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C3);
      end
      OTCPU_F_ALU_IMM: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C2);
      end

      // logic ops with a direct byte as destination
      OTCPU_F_LOGIC_DIR_A: begin
        t = otcpu_timing_s'(`OTCPU_T_B2_C4);
      end
      OTCPU_F_LOGIC_DIR_IMM: begin
        t = otcpu_timing_s'(`OTCPU_T_B3_C4);
      end

      // accumulator-only operations
      OTCPU_F_CLR_A: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C1);
      end
      OTCPU_F_ROTATE: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C1);
      end
      OTCPU_F_SWAP: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C1);
      end
      OTCPU_F_CPL_A: begin
        t = otcpu_timing_s'(`OTCPU_T_B1_C2);
      end

      default: begin
        t = otcpu_timing_s'(`OTCPU_T_NONE);
      end
    endcase

    // zero timing marks the refused external transfer
    return t;
  endfunction

  // sequencer state, program counter and captured instruction
  otcpu_state_e state_q;
  logic [15:0] pc_q;
  logic [2:0] cnt_q;
  otcpu_insn_s insn_q;
  otcpu_timing_s tim_q;
  logic done_q;
  logic unsup_q;
  // combinational decode of the byte on the code port
  otcpu_timing_s new_tim;
  logic new_ext;
  logic last_exec;
  logic fetch_opnd;

  // decode of the opcode cycle and of the running instruction
  assign new_tim = timing_of(form_in);
  assign new_ext = (form_in == OTCPU_F_AUX_EXTERNAL);
  // compare against cycles minus one so the counter never wraps
  assign last_exec = (cnt_q == (tim_q.cycle_count - `OTCPU_CNT_ONE));
  assign fetch_opnd = (cnt_q < {1'b0, tim_q.byte_count});

  // state and cycle counter, one step per core clock, never prescaled
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= OTCPU_ST_OPCODE;
      cnt_q <= `OTCPU_CNT_ZERO;
    end else begin
      case (state_q)
        OTCPU_ST_OPCODE: begin
          // single-cycle forms and the refused external transfer stay here
          if (!new_ext && (new_tim.cycle_count != `OTCPU_CNT_ONE)) begin
            state_q <= OTCPU_ST_EXEC;
            cnt_q <= `OTCPU_CNT_ONE;
          end
        end
        OTCPU_ST_EXEC: begin
          // count up to the last execution cycle, then back to an opcode fetch
          if (last_exec) begin
            state_q <= OTCPU_ST_OPCODE;
            cnt_q <= `OTCPU_CNT_ZERO;
          end else begin
            cnt_q <= cnt_q + `OTCPU_CNT_ONE;
          end
        end
        default: begin
          state_q <= OTCPU_ST_OPCODE;
          cnt_q <= `OTCPU_CNT_ZERO;
        end
      endcase
    end
  end

  // program counter: one step per byte fetched, opcode first
  // forms with more cycles than bytes hold pc while they finish
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc_q <= `OTCPU_PC_RESET;
    end else if (state_q == OTCPU_ST_OPCODE || fetch_opnd) begin
      pc_q <= pc_q + `OTCPU_PC_STEP;
    end
  end

  // instruction bytes land in ascending order
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      insn_q <= '0;
      tim_q <= otcpu_timing_s'(`OTCPU_T_NONE);
    end else if (state_q == OTCPU_ST_OPCODE) begin
      insn_q.form <= form_in;
      insn_q.opcode <= code_byte;
      insn_q.operand1 <= 8'h00;
      insn_q.operand2 <= 8'h00;
      tim_q <= new_tim;
    end else if (fetch_opnd) begin
      // stale operands cleared at opcode time so short forms show zeros
      if (cnt_q == `OTCPU_CNT_ONE) begin
        insn_q.operand1 <= code_byte;
      end else begin
        insn_q.operand2 <= code_byte;
      end
    end
  end

  // completion and refusal pulses, one cycle after the deciding cycle
  // refusal never raises done, so software sees exactly one of the two
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
      unsup_q <= 1'b0;
    end else if (state_q == OTCPU_ST_OPCODE) begin
      done_q <= !new_ext && (new_tim.cycle_count == `OTCPU_CNT_ONE);
      unsup_q <= new_ext;
    end else begin
      done_q <= last_exec;
      unsup_q <= 1'b0;
    end
  end

  // every output comes straight from a flip-flop
  assign code_addr = pc_q;
  assign insn = insn_q;
  assign insn_timing = tim_q;
  assign exec_cycle = cnt_q;
  assign insn_done = done_q;
  assign unsupported = unsup_q;
endmodule

// [shared/otcpu_params.svh]
// constants for the instruction length and cycle sequencer
// assumes one core clock per execution cycle and a byte-wide code port
`ifndef OTCPU_PARAMS_SVH
`define OTCPU_PARAMS_SVH

// program counter start and step
`define OTCPU_PC_RESET 16'h0000
`define OTCPU_PC_STEP 16'h0001

// cycle counter values
`define OTCPU_CNT_ZERO 3'h0
`define OTCPU_CNT_ONE 3'h1

// packed timing words: {byte count[1:0], cycle count[2:0]}
`define OTCPU_T_B1_C1 5'h09
`define OTCPU_T_B1_C2 5'h0a
`define OTCPU_T_B1_C3 5'h0b
`define OTCPU_T_B1_C4 5'h0c
`define OTCPU_T_B2_C2 5'h12
`define OTCPU_T_B2_C3 5'h13
`define OTCPU_T_B2_C4 5'h14
`define OTCPU_T_B3_C3 5'h1b
`define OTCPU_T_B3_C4 5'h1c
// no timing exists for the unsupported external transfers
`define OTCPU_T_NONE 5'h00

`endif

// [shared/otcpu_pkg.sv]
// types for the instruction length and cycle sequencer
// assumes the classifier outside maps each opcode byte onto one form
package otcpu_pkg;

  // operand forms whose length and timing the sequencer knows
  typedef enum logic [5:0] {
    OTCPU_F_MOV_A_BANK,
    OTCPU_F_MOV_A_DIR,
    OTCPU_F_MOV_A_IND,
    OTCPU_F_MOV_A_IMM,
    OTCPU_F_MOV_BANK_IMM,
    OTCPU_F_MOV_BANK_A,
    OTCPU_F_MOV_BANK_DIR,
    OTCPU_F_MOV_DIR_A,
    OTCPU_F_MOV_DIR_BANK,
    OTCPU_F_MOV_DIR_IMM,
    OTCPU_F_MOV_DIR_DIR,
    OTCPU_F_MOV_DIR_IND,
    OTCPU_F_MOV_IND_A,
    OTCPU_F_MOV_IND_DIR,
    OTCPU_F_MOV_IND_IMM,
    OTCPU_F_LOAD_DATA_POINTER,
    OTCPU_F_CODE_BYTE_READ_DP,
    OTCPU_F_CODE_BYTE_READ_PC,
    OTCPU_F_AUX_RD_8,
    OTCPU_F_AUX_RD_16,
    OTCPU_F_AUX_WR_8,
    OTCPU_F_AUX_WR_16,
    OTCPU_F_AUX_EXTERNAL,
    OTCPU_F_PUSH,
    OTCPU_F_POP,
    OTCPU_F_XCH_BANK,
    OTCPU_F_XCH_DIR,
    OTCPU_F_XCH_IND,
    OTCPU_F_LOW_NIBBLE_EXCHANGE,
    OTCPU_F_ALU_BANK,
    OTCPU_F_ALU_DIR,
    OTCPU_F_ALU_IND,
    OTCPU_F_ALU_IMM,
    OTCPU_F_LOGIC_DIR_A,
    OTCPU_F_LOGIC_DIR_IMM,
    OTCPU_F_CLR_A,
    OTCPU_F_ROTATE,
    OTCPU_F_SWAP,
    OTCPU_F_CPL_A
  } otcpu_form_e;

  // length and execution time of one instruction
  typedef struct packed {
    logic [1:0] byte_count;
    logic [2:0] cycle_count;
  } otcpu_timing_s;

  // instruction as fetched, handed to the datapath
  typedef struct packed {
    otcpu_form_e form;
    logic [7:0] opcode;
    logic [7:0] operand1;
    logic [7:0] operand2;
  } otcpu_insn_s;

  // sequencer states
  typedef enum logic {
    OTCPU_ST_OPCODE,
    OTCPU_ST_EXEC
  } otcpu_state_e;

endpackage

// [tb/otcpu_timing_monitor.sv]
// checker for the instruction sequencer, bound to its ports
// assumes one ref_clk domain with async active-high rst
`timescale 1ns/100ps
module otcpu_timing_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] code_addr,
  input wire otcpu_pkg::otcpu_timing_s insn_timing,
  input wire logic [2:0] exec_cycle,
  input wire logic insn_done,
  input wire logic unsupported
);
  import otcpu_pkg::*;
  // one clock domain, so shared clocking and reset gating
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_done_opcode: assert property (insn_done |-> exec_cycle == 3'h0)
    else $error("done outside an opcode cycle");
  a_exec_bound: assert property (exec_cycle != 3'h0 |-> exec_cycle < insn_timing.cycle_count)
    else $error("execution cycle beyond count");
  a_exec_step: assert property ((exec_cycle != 3'h0 && exec_cycle + 1 < insn_timing.cycle_count)
    |=> exec_cycle == $past(exec_cycle) + 3'h1)
    else $error("execution cycle did not step");
  a_last_done: assert property ((exec_cycle != 3'h0 && exec_cycle + 1 == insn_timing.cycle_count)
    |=> insn_done && exec_cycle == 3'h0)
    else $error("no done after last cycle");
  a_done_timing: assert property (insn_done |-> $past(exec_cycle) + 1 == insn_timing.cycle_count)
    else $error("done at wrong cycle");
  a_pc_opcode: assert property (exec_cycle == 3'h0 |=> code_addr == $past(code_addr) + 16'h1)
    else $error("opcode fetch did not advance pc");
  a_pc_operand: assert property ((exec_cycle != 3'h0 && exec_cycle < insn_timing.byte_count)
    |=> code_addr == $past(code_addr) + 16'h1)
    else $error("operand fetch did not advance pc");
  a_pc_hold: assert property ((exec_cycle != 3'h0 && exec_cycle >= insn_timing.byte_count)
    |=> $stable(code_addr))
    else $error("pc moved past the last byte");
  a_refuse_quiet: assert property (unsupported |-> !insn_done && exec_cycle == 3'h0)
    else $error("refused form behaved as executed");
endmodule

bind otcpu_timing_seq otcpu_timing_monitor u_otcpu_timing_monitor (.ref_clk(ref_clk),
  .rst(rst), .code_addr(code_addr), .insn_timing(insn_timing), .exec_cycle(exec_cycle),
  .insn_done(insn_done), .unsupported(unsupported));

// [tb/otcpu_timing_seq_tb_top.sv]
// self-checking bench: runs every form through the sequencer from a code memory
// assumes combinational code memory and form classifier indexed by code_addr
`timescale 1ns/100ps
module otcpu_timing_seq_tb_top;
  import otcpu_pkg::*;
  typedef struct packed {logic sup; otcpu_form_e f; otcpu_timing_s t;
    logic [23:0] ops; logic [15:0] nxt;} otcpu_note_s;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] code_addr;
  logic [7:0] mem [256];
  otcpu_form_e fmem [256];
  otcpu_insn_s insn;
  otcpu_timing_s insn_timing;
  logic [2:0] exec_cycle;
  logic insn_done, unsupported;
  otcpu_note_s notes[$];
  int failures = 0;
  int compares = 0;
  int cnt = 0;
  // code memory answers in the same cycle, as the fetch contract needs
  wire logic [7:0] code_byte = mem[code_addr[7:0]];
  wire otcpu_form_e form_in = fmem[code_addr[7:0]];

  otcpu_timing_seq u_otcpu_timing_seq (.ref_clk(ref_clk), .rst(rst), .code_addr(code_addr),
    .code_byte(code_byte), .form_in(form_in), .insn(insn), .insn_timing(insn_timing),
    .exec_cycle(exec_cycle), .insn_done(insn_done), .unsupported(unsupported));

  // 125 MHz core clock
  initial forever #4 ref_clk = ~ref_clk;

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // {bytes, cycles} per form; zero marks the refused external form
  function automatic otcpu_timing_s exp_t(input otcpu_form_e f);
    case (f)
      OTCPU_F_MOV_A_BANK, OTCPU_F_CLR_A, OTCPU_F_ROTATE, OTCPU_F_SWAP: return 5'h09;
      OTCPU_F_MOV_A_IND, OTCPU_F_MOV_BANK_A, OTCPU_F_ALU_BANK, OTCPU_F_CPL_A: return 5'h0a;
      OTCPU_F_MOV_IND_A, OTCPU_F_AUX_RD_8, OTCPU_F_AUX_RD_16, OTCPU_F_AUX_WR_8, OTCPU_F_AUX_WR_16,
        OTCPU_F_XCH_BANK, OTCPU_F_ALU_IND: return 5'h0b;
      OTCPU_F_CODE_BYTE_READ_DP, OTCPU_F_CODE_BYTE_READ_PC, OTCPU_F_XCH_IND,
        OTCPU_F_LOW_NIBBLE_EXCHANGE: return 5'h0c;
      OTCPU_F_MOV_A_DIR, OTCPU_F_MOV_A_IMM, OTCPU_F_MOV_BANK_IMM, OTCPU_F_ALU_IMM: return 5'h12;
      OTCPU_F_MOV_DIR_A, OTCPU_F_MOV_DIR_BANK, OTCPU_F_MOV_IND_DIR, OTCPU_F_MOV_IND_IMM,
        OTCPU_F_POP, OTCPU_F_ALU_DIR: return 5'h13;
      OTCPU_F_MOV_DIR_IMM, OTCPU_F_LOAD_DATA_POINTER: return 5'h1b;
      OTCPU_F_MOV_DIR_DIR, OTCPU_F_LOGIC_DIR_IMM: return 5'h1c;
      OTCPU_F_AUX_EXTERNAL: return 5'h00;
      default: return 5'h14;
    endcase
  endfunction

  // lay out one program, in enum order or random order, and note each result
  task automatic load(input bit rnd);
    int a;
    otcpu_form_e f;
    otcpu_timing_s t;
    a = 0;
    f = f.first();
    notes.delete();
    foreach (mem[i]) begin
      mem[i] = 8'($urandom);
      fmem[i] = OTCPU_F_MOV_A_BANK;
    end
    for (int k = 0; k < f.num(); k++) begin
      if (rnd) f = otcpu_form_e'($urandom_range(f.num() - 1));
      t = exp_t(f);
      fmem[a] = f;
      notes.push_back('{t == 5'h00, f, t, {mem[a], t.byte_count > 1 ? mem[a + 1] : 8'h00,
        t.byte_count > 2 ? mem[a + 2] : 8'h00}, 16'(a + (t == 5'h00 ? 1 : t.byte_count))});
      a += (t == 5'h00) ? 1 : t.byte_count;
      if (!rnd) f = f.next();
    end
  endtask

  // result watcher: cycles between completions, pc, fetched bytes
  // sampled mid-cycle so the registered outputs have settled
  always @(negedge ref_clk) begin
    otcpu_note_s n;
    if (rst) cnt = 0;
    else if ((insn_done | unsupported) === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      chk(unsupported, n.sup, "refusal flag");
      chk(cnt, n.sup ? 3'h1 : n.t.cycle_count, "cycle count");
      chk(code_addr, n.nxt, "next pc");
      if (!n.sup) chk({insn.form, insn_timing, insn.opcode, insn.operand1, insn.operand2},
        {n.f, n.t, n.ops}, "insn and timing");
      cnt = 1;
    end else cnt++;
  end

  // watchdog sized well above two programs of at most four cycles per form
  initial begin
    repeat (2000) @(posedge ref_clk);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end

  // round 0 in enum order, round 1 random forms after a mid-run reset
  initial begin
    void'($urandom(16));
    for (int r = 0; r < 2; r++) begin
      rst <= 1'b1;
      load(r[0]);
      repeat (8) @(posedge ref_clk);
      chk({code_addr, exec_cycle, insn_done}, 20'h0, "reset state");
      rst <= 1'b0;
      for (int w = 0; w < 600 && notes.size() > 0; w++) @(posedge ref_clk);
      chk(notes.size(), 0, "program drained");
      $display("test %0d done", r);
    end
    report_and_stop();
  end
endmodule
